// *** hw/dmtc_pkg.sv ***
// Purpose: shared constants for the dual mode timer/counter unit
// Assumes: byte wide special function register bus of the cpu core
// Notes: offsets are the cpu's own register addresses
package dmtc_pkg;
    // register addresses
    localparam logic [7:0] DMTC_ADDR_TIMER_CONTROL_REG = 8'h88;
    localparam logic [7:0] DMTC_ADDR_TIMER_MODE_REG = 8'h89;
    localparam logic [7:0] DMTC_ADDR_TL0 = 8'h8A;
    localparam logic [7:0] DMTC_ADDR_TL1 = 8'h8B;
    localparam logic [7:0] DMTC_ADDR_TH0 = 8'h8C;
    localparam logic [7:0] DMTC_ADDR_TH1 = 8'h8D;
    localparam logic [7:0] DMTC_ADDR_CLOCK_CONTROL_REG = 8'h8E;
    // reset values
    localparam logic [7:0] DMTC_RST_TIMER_MODE_REG = 8'h00;
    localparam logic [7:0] DMTC_RST_CLOCK_CONTROL_REG = 8'h01;
    localparam logic [7:0] DMTC_RST_TL0 = 8'h10;
    localparam logic [7:0] DMTC_RST_TL1 = 8'h00;
    localparam logic [7:0] DMTC_RST_TH0 = 8'h00;
    localparam logic [7:0] DMTC_RST_TH1 = 8'h00;
    // timer_mode_reg fields
    localparam int DMTC_TIMER_MODE_REG_GATE1 = 7;
    localparam int DMTC_TIMER_MODE_REG_CT1 = 6;
    localparam int DMTC_TIMER_MODE_REG_M1_HI = 5;
    localparam int DMTC_TIMER_MODE_REG_M1_LO = 4;
    localparam int DMTC_TIMER_MODE_REG_GATE0 = 3;
    localparam int DMTC_TIMER_MODE_REG_CT0 = 2;
    localparam int DMTC_TIMER_MODE_REG_M0_HI = 1;
    localparam int DMTC_TIMER_MODE_REG_M0_LO = 0;
    // timer_control_reg fields
    localparam int DMTC_TIMER_CONTROL_REG_TF1 = 7;
    localparam int DMTC_TIMER_CONTROL_REG_TR1 = 6;
    localparam int DMTC_TIMER_CONTROL_REG_TF0 = 5;
    localparam int DMTC_TIMER_CONTROL_REG_TR0 = 4;
    // clock_control_reg fields
    localparam int DMTC_CLOCK_CONTROL_REG_T1M = 4;
    localparam int DMTC_CLOCK_CONTROL_REG_T0M = 3;
    // event pins as port bits
    localparam int DMTC_P0_T0_BIT = 5;
    localparam int DMTC_P0_T1_BIT = 6;
    localparam int DMTC_P1_T2_BIT = 0;
    // prescaler counts
    localparam logic [3:0] DMTC_DIV_FAST = 4'h4;
    localparam logic [3:0] DMTC_DIV_SLOW = 4'hC;
    // modes
    typedef enum logic [1:0] {
        DMTC_MODE_13BIT = 2'b00,
        DMTC_MODE_16BIT = 2'b01,
        DMTC_MODE_RELOAD = 2'b10,
        DMTC_MODE_SPLIT = 2'b11
    } dmtc_mode_t;
    // result of one count step
    typedef struct packed {
        logic [7:0] tl;
        logic [7:0] th;
        logic ovf;
    } dmtc_step_t;
endpackage

// *** hw/dmtc_pin_sync.sv ***
// Purpose: two flip-flop synchroniser with falling edge detect
// Assumes: pin is asynchronous to clk_i
// Notes: the edge is seen one to two cycles after the pin moves
`timescale 1ns/100ps
`default_nettype none
module dmtc_pin_sync
    import dmtc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // pin and results
    input wire logic pin_i,
    output logic level_o,
    output logic fall_o
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } dmtc_sync_t;

    dmtc_sync_t s;
    dmtc_sync_t next_s;

    ////////////////////////////////////////////////////////////////////
    // next state: meta feeds only sync; edge looks at sync and prev
    always_comb begin
        next_s = s;
        next_s.meta = pin_i;
        next_s.sync = s.meta;
        next_s.prev = s.sync;
    end

    // pins idle high, so reset to one avoids a false edge
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s <= 3'b111;
        end else begin
            s <= next_s;
        end
    end

    assign level_o = s.sync;
    assign fall_o = s.prev & ~s.sync;
endmodule // dmtc_pin_sync
`default_nettype wire

// *** hw/dmtc_timer.sv ***
// Purpose: timers 0 and 1 with shared mode register, timer 2 event pin
// Assumes: cpu core drives the sfr bus on clk_i, reads take one cycle
// Notes: timer 2 counting lives elsewhere; only its event is made here
// Notes on behaviour
// - each timer counts cpu clock ticks or its own external event pin
// - event pins are port 0 bit 5, port 0 bit 6, port 1 bit 0
// - each 16-bit count is read and written as low and high bytes
// - mode 00 13-bit, 01 16-bit, 10 8-bit reload, 11 split
// - timer 1 mode in bits 5:4, timer 0 mode in bits 1:0
// - timer 1 gate bit 7 makes counting need int1 pin high
// - timer 0 gate bit 3 makes counting need int0 pin high
// - bit 6 picks timer 1 source: clk/4 or clk/12, or event pin
// - bit 2 picks timer 0 source: clk/4 or clk/12, or event pin
// - timer 1 overflow sets its flag unless timer 0 is split, vectoring clears it
// - timer 0 overflow sets its flag, vectoring clears it
`timescale 1ns/100ps
`default_nettype none
module dmtc_timer
    import dmtc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // special function register bus
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // interrupt vector acknowledge from the core
    input wire logic timer0_vector_ack_i,
    input wire logic timer1_vector_ack_i,
    // pins
    input wire logic [7:0] port0_pins_i,
    input wire logic [2:0] port1_pins_i,
    input wire logic ext_int0_pin_n_i,
    input wire logic ext_int1_pin_n_i,
    // results
    output logic timer0_overflow_flag_o,
    output logic timer1_overflow_flag_o,
    output logic timer2_event_o
);
    typedef struct packed {
        logic [7:0] timer_mode_reg;
        logic [7:0] clock_control_reg;
        logic timer1_overflow_flag;
        logic timer1_run;
        logic timer0_overflow_flag;
        logic timer0_run;
        logic [7:0] timer0_count_low;
        logic [7:0] timer0_count_high;
        logic [7:0] timer1_count_low;
        logic [7:0] timer1_count_high;
        logic [3:0] div_fast;
        logic [3:0] div_slow;
        logic tick_fast;
        logic tick_slow;
        logic timer2_event;
        logic [7:0] rdata;
    } dmtc_state_t;

    dmtc_state_t s;
    dmtc_state_t next_s;

    logic ev0_fall;
    logic ev1_fall;
    logic ev2_fall;
    logic int0_level;
    logic int1_level;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers, event pins are alternate port functions
    dmtc_pin_sync u_sync_ev0 (
        .clk_i(clk_i), .nrst_i(nrst_i),
        .pin_i(port0_pins_i[DMTC_P0_T0_BIT]),
        .level_o(), .fall_o(ev0_fall));
    dmtc_pin_sync u_sync_ev1 (
        .clk_i(clk_i), .nrst_i(nrst_i),
        .pin_i(port0_pins_i[DMTC_P0_T1_BIT]),
        .level_o(), .fall_o(ev1_fall));
    dmtc_pin_sync u_sync_ev2 (
        .clk_i(clk_i), .nrst_i(nrst_i),
        .pin_i(port1_pins_i[DMTC_P1_T2_BIT]),
        .level_o(), .fall_o(ev2_fall));
    dmtc_pin_sync u_sync_int0 (
        .clk_i(clk_i), .nrst_i(nrst_i),
        .pin_i(ext_int0_pin_n_i),
        .level_o(int0_level), .fall_o());
    dmtc_pin_sync u_sync_int1 (
        .clk_i(clk_i), .nrst_i(nrst_i),
        .pin_i(ext_int1_pin_n_i),
        .level_o(int1_level), .fall_o());

    ////////////////////////////////////////////////////////////////////
    // one count step of a timer in all four modes; the split high byte is handled apart
    function automatic dmtc_step_t dmtc_step(input logic [1:0] mode,
            input logic [7:0] tl, input logic [7:0] th);
        logic [12:0] c13;
        logic [15:0] c16;
        dmtc_step_t r;
        c13 = {th, tl[4:0]} + 13'h0001;
        c16 = {th, tl} + 16'h0001;
        r.tl = tl;
        r.th = th;
        r.ovf = 1'b0;
        unique case (dmtc_mode_t'(mode))
            DMTC_MODE_13BIT: begin
                r.tl = {tl[7:5], c13[4:0]};
                r.th = c13[12:5];
                r.ovf = &{th, tl[4:0]};
            end
            DMTC_MODE_16BIT: begin
                r.tl = c16[7:0];
                r.th = c16[15:8];
                r.ovf = &{th, tl};
            end
            DMTC_MODE_RELOAD: begin
                r.ovf = &tl;
                r.tl = r.ovf ? th : tl + 8'h01;
            end
            DMTC_MODE_SPLIT: begin
                r.ovf = &tl;
                r.tl = tl + 8'h01;
            end
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [1:0] mode0;
        logic [1:0] mode1;
        logic cpu_tick0;
        logic cpu_tick1;
        logic inc0;
        logic inc1;
        logic inc0_high;
        logic set0;
        logic set1;
        dmtc_step_t st0;
        dmtc_step_t st1;
        next_s = s;
        mode0 = {s.timer_mode_reg[DMTC_TIMER_MODE_REG_M0_HI],
                 s.timer_mode_reg[DMTC_TIMER_MODE_REG_M0_LO]};
        mode1 = {s.timer_mode_reg[DMTC_TIMER_MODE_REG_M1_HI],
                 s.timer_mode_reg[DMTC_TIMER_MODE_REG_M1_LO]};
        // prescalers run free so a source switch takes effect at once
        next_s.div_fast = (s.div_fast == DMTC_DIV_FAST - 4'h1) ?
            4'h0 : s.div_fast + 4'h1;
        next_s.div_slow = (s.div_slow == DMTC_DIV_SLOW - 4'h1) ?
            4'h0 : s.div_slow + 4'h1;
        next_s.tick_fast = (s.div_fast == DMTC_DIV_FAST - 4'h1);
        next_s.tick_slow = (s.div_slow == DMTC_DIV_SLOW - 4'h1);
        // tick selection, set bit means divide by four
        cpu_tick0 = s.clock_control_reg[DMTC_CLOCK_CONTROL_REG_T0M] ?
            s.tick_fast : s.tick_slow;
        cpu_tick1 = s.clock_control_reg[DMTC_CLOCK_CONTROL_REG_T1M] ?
            s.tick_fast : s.tick_slow;
        inc0 = (s.timer_mode_reg[DMTC_TIMER_MODE_REG_CT0] ? ev0_fall : cpu_tick0)
            & s.timer0_run
            & (~s.timer_mode_reg[DMTC_TIMER_MODE_REG_GATE0] | int0_level);
        inc1 = (s.timer_mode_reg[DMTC_TIMER_MODE_REG_CT1] ? ev1_fall : cpu_tick1)
            & s.timer1_run
            & (~s.timer_mode_reg[DMTC_TIMER_MODE_REG_GATE1] | int1_level);
        // split high byte counts cpu ticks under timer 1 run only
        inc0_high = (mode0 == DMTC_MODE_SPLIT) & s.timer1_run & cpu_tick0;
        set0 = 1'b0;
        set1 = 1'b0;
        st0 = dmtc_step(mode0, s.timer0_count_low, s.timer0_count_high);
        st1 = dmtc_step(mode1, s.timer1_count_low, s.timer1_count_high);
        // timer 0
        if (inc0) begin
            next_s.timer0_count_low = st0.tl;
            next_s.timer0_count_high = st0.th;
            set0 = st0.ovf;
        end
        if (inc0_high) begin
            next_s.timer0_count_high = s.timer0_count_high + 8'h01;
            set1 = &s.timer0_count_high;
        end
        // timer 1 halts in split mode; its flag is lent to timer 0
        if (inc1 && mode1 != DMTC_MODE_SPLIT) begin
            next_s.timer1_count_low = st1.tl;
            next_s.timer1_count_high = st1.th;
            if (mode0 != DMTC_MODE_SPLIT) begin
                set1 = st1.ovf;
            end
        end
        // register writes win over counting in the same cycle, except a fresh overflow still sets its flag
        if (sfr_wr_i) begin
            unique case (sfr_addr_i)
                DMTC_ADDR_TIMER_MODE_REG: next_s.timer_mode_reg = sfr_wdata_i;
                DMTC_ADDR_CLOCK_CONTROL_REG: next_s.clock_control_reg = sfr_wdata_i;
                DMTC_ADDR_TL0: next_s.timer0_count_low = sfr_wdata_i;
                DMTC_ADDR_TH0: next_s.timer0_count_high = sfr_wdata_i;
                DMTC_ADDR_TL1: next_s.timer1_count_low = sfr_wdata_i;
                DMTC_ADDR_TH1: next_s.timer1_count_high = sfr_wdata_i;
                DMTC_ADDR_TIMER_CONTROL_REG: begin
                    next_s.timer1_overflow_flag = sfr_wdata_i[DMTC_TIMER_CONTROL_REG_TF1];
                    next_s.timer1_run = sfr_wdata_i[DMTC_TIMER_CONTROL_REG_TR1];
                    next_s.timer0_overflow_flag = sfr_wdata_i[DMTC_TIMER_CONTROL_REG_TF0];
                    next_s.timer0_run = sfr_wdata_i[DMTC_TIMER_CONTROL_REG_TR0];
                end
                default: ;
            endcase
        end
        // vectoring clears, a fresh overflow in the same cycle wins
        if (timer0_vector_ack_i) begin
            next_s.timer0_overflow_flag = 1'b0;
        end
        if (timer1_vector_ack_i) begin
            next_s.timer1_overflow_flag = 1'b0;
        end
        if (set0) begin
            next_s.timer0_overflow_flag = 1'b1;
        end
        if (set1) begin
            next_s.timer1_overflow_flag = 1'b1;
        end
        next_s.timer2_event = ev2_fall;
        // read data shows state before this cycle's update
        unique case (sfr_addr_i)
            DMTC_ADDR_TIMER_MODE_REG: next_s.rdata = s.timer_mode_reg;
            DMTC_ADDR_CLOCK_CONTROL_REG: next_s.rdata = s.clock_control_reg;
            DMTC_ADDR_TL0: next_s.rdata = s.timer0_count_low;
            DMTC_ADDR_TH0: next_s.rdata = s.timer0_count_high;
            DMTC_ADDR_TL1: next_s.rdata = s.timer1_count_low;
            DMTC_ADDR_TH1: next_s.rdata = s.timer1_count_high;
            DMTC_ADDR_TIMER_CONTROL_REG: next_s.rdata = {s.timer1_overflow_flag,
                s.timer1_run, s.timer0_overflow_flag, s.timer0_run, 4'h0};
            default: next_s.rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s <= '0;
            s.timer_mode_reg <= DMTC_RST_TIMER_MODE_REG;
            s.clock_control_reg <= DMTC_RST_CLOCK_CONTROL_REG;
            s.timer0_count_low <= DMTC_RST_TL0;
            s.timer0_count_high <= DMTC_RST_TH0;
            s.timer1_count_low <= DMTC_RST_TL1;
            s.timer1_count_high <= DMTC_RST_TH1;
        end else begin
            s <= next_s;
        end
    end

    assign sfr_rdata_o = s.rdata;
    assign timer0_overflow_flag_o = s.timer0_overflow_flag;
    assign timer1_overflow_flag_o = s.timer1_overflow_flag;
    assign timer2_event_o = s.timer2_event;
endmodule // dmtc_timer
`default_nettype wire

// *** bench/dmtc_timer_asserts.sv ***
// Purpose: port level checks for the timer/counter unit
// Assumes: reads answer one cycle after the address is taken
// Notes: count bytes are only seen through reads, so checks sit on the bus
`timescale 1ns/100ps
`default_nettype none
module dmtc_timer_chk
    import dmtc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register bus and acknowledges
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic timer0_vector_ack_i,
    input wire logic timer1_vector_ack_i,
    // pins and results
    input wire logic [7:0] port0_pins_i,
    input wire logic [2:0] port1_pins_i,
    input wire logic ext_int0_pin_n_i,
    input wire logic ext_int1_pin_n_i,
    input wire logic timer0_overflow_flag_o,
    input wire logic timer1_overflow_flag_o,
    input wire logic timer2_event_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic map_hit;
    logic timer_control_reg_wr;
    // decode helpers shared by several properties
    assign map_hit = sfr_addr_i >= DMTC_ADDR_TIMER_CONTROL_REG && sfr_addr_i <= DMTC_ADDR_CLOCK_CONTROL_REG;
    assign timer_control_reg_wr = sfr_wr_i && sfr_addr_i == DMTC_ADDR_TIMER_CONTROL_REG;
    ////////////////////////////////////////////////////////////////////////
    AST_RD_UNMAPPED: assert property (!map_hit |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_TIMER_MODE_REG_WR_RD: assert property ((sfr_wr_i && sfr_addr_i == DMTC_ADDR_TIMER_MODE_REG)
        ##1 (!sfr_wr_i && sfr_addr_i == DMTC_ADDR_TIMER_MODE_REG)
        |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
        else $error("mode register read differs from write");
    AST_TIMER_MODE_REG_HOLD: assert property ((!sfr_wr_i && sfr_addr_i == DMTC_ADDR_TIMER_MODE_REG)[*2]
        |-> ##1 $stable(sfr_rdata_o))
        else $error("mode register changed without write");
    AST_TIMER_CONTROL_REG_RD: assert property (!sfr_wr_i && sfr_addr_i == DMTC_ADDR_TIMER_CONTROL_REG
        |=> sfr_rdata_o[7] == $past(timer1_overflow_flag_o)
        && sfr_rdata_o[5] == $past(timer0_overflow_flag_o) && sfr_rdata_o[3:0] == 4'h0)
        else $error("control register flags differ from flag outputs");
    AST_TF0_CLR: assert property ($fell(timer0_overflow_flag_o)
        |-> $past(timer0_vector_ack_i || timer_control_reg_wr))
        else $error("timer 0 flag cleared without cause");
    AST_TF1_CLR: assert property ($fell(timer1_overflow_flag_o)
        |-> $past(timer1_vector_ack_i || timer_control_reg_wr))
        else $error("timer 1 flag cleared without cause");
    AST_TF0_SET: assert property (timer_control_reg_wr && sfr_wdata_i[DMTC_TIMER_CONTROL_REG_TF0]
        && !timer0_vector_ack_i |=> timer0_overflow_flag_o)
        else $error("timer 0 flag not set by write");
    AST_T2_EDGE: assert property ($fell(port1_pins_i[DMTC_P1_T2_BIT])
        |-> ##[1:5] timer2_event_o)
        else $error("timer 2 event pin edge lost");
    AST_T2_PULSE: assert property (timer2_event_o |=> !timer2_event_o)
        else $error("timer 2 event longer than one cycle");
    // main scenarios reached
    cover property ($rose(timer0_overflow_flag_o));
    cover property ($rose(timer1_overflow_flag_o));
    cover property (timer2_event_o);
endmodule // dmtc_timer_chk
bind dmtc_timer dmtc_timer_chk u_dmtc_timer_chk (.clk_i(clk_i), .nrst_i(nrst_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .timer0_vector_ack_i(timer0_vector_ack_i),
    .timer1_vector_ack_i(timer1_vector_ack_i), .port0_pins_i(port0_pins_i),
    .port1_pins_i(port1_pins_i), .ext_int0_pin_n_i(ext_int0_pin_n_i),
    .ext_int1_pin_n_i(ext_int1_pin_n_i),
    .timer0_overflow_flag_o(timer0_overflow_flag_o),
    .timer1_overflow_flag_o(timer1_overflow_flag_o),
    .timer2_event_o(timer2_event_o));
`default_nettype wire

// *** bench/dmtc_pin_partner.sv ***
// Purpose: model of the event and gate pins outside the unit
// Assumes: port pins have pull-ups, so released pins read high
// Notes: pulses last four cycles so the two flop synchroniser sees them
`timescale 1ns/100ps
`default_nettype none
module dmtc_pin_partner (
    // clock
    input wire logic clk_i,
    // pins toward the unit
    output logic [7:0] port0_o,
    output logic [2:0] port1_o,
    output logic ext_int0_pin_n_o,
    output logic ext_int1_pin_n_o
);
    logic [10:0] pins = 11'h7FF;
    logic [1:0] gates = 2'h3;
    // port 1 sits above port 0 in one vector
    assign port0_o = pins[7:0];
    assign port1_o = pins[10:8];
    assign ext_int0_pin_n_o = gates[0];
    assign ext_int1_pin_n_o = gates[1];
    // n low pulses on every pin in the mask
    task automatic pulse(input logic [10:0] m, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            pins <= pins & ~m;
            repeat (4) @(posedge clk_i);
            pins <= pins | m;
            repeat (3) @(posedge clk_i);
        end
    endtask
    // gate pin levels, high lets the timer count
    task automatic gate(input logic [1:0] g);
        @(posedge clk_i);
        gates <= g;
    endtask
endmodule // dmtc_pin_partner
`default_nettype wire

// *** bench/test_dual_mode_timer_counter.sv ***
// Purpose: register level test of the timer/counter unit
// Assumes: 250 MHz clock, prescaler free running so counts get a window
// Notes: every run starts the low count at F0, so sixteen ticks give an overflow in all but the event pin run
`timescale 1ns/100ps
`default_nettype none
module test_dual_mode_timer_counter
    import dmtc_pkg::*;
;
    logic clk_i;
    logic nrst_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic ack0 = 1'b0;
    logic ack1 = 1'b0;
    logic [7:0] p0;
    logic [2:0] p1;
    logic g0;
    logic g1;
    logic tf0;
    logic tf1;
    logic ev2;
    int ev2_n = 0;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] ra [8] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h90};
    logic [7:0] rv [8] = '{8'h00, DMTC_RST_TIMER_MODE_REG, DMTC_RST_TL0, DMTC_RST_TL1,
        DMTC_RST_TH0, DMTC_RST_TH1, DMTC_RST_CLOCK_CONTROL_REG, 8'h00};
    dmtc_timer u_dmtc_timer (.clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(addr),
        .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .timer0_vector_ack_i(ack0), .timer1_vector_ack_i(ack1),
        .port0_pins_i(p0), .port1_pins_i(p1), .ext_int0_pin_n_i(g0),
        .ext_int1_pin_n_i(g1), .timer0_overflow_flag_o(tf0),
        .timer1_overflow_flag_o(tf1), .timer2_event_o(ev2));
    dmtc_pin_partner u_dmtc_pin_partner (.clk_i(clk_i), .port0_o(p0),
        .port1_o(p1), .ext_int0_pin_n_o(g0), .ext_int1_pin_n_o(g1));
    ////////////////////////////////////////////////////////////////////////
    // clock and a cycle ceiling well above the roughly 1400 cycles needed
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    // timer 2 event pulses, counted off the launching edge to avoid a race
    always @(negedge clk_i) begin
        if (ev2 === 1'b1) begin
            ev2_n++;
        end
    end
    task automatic end_of_test();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one write pulse; strobe drops at the edge that takes it
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr <= a;
        @(posedge clk_i);
        @(negedge clk_i);
        cmp(rdata, exp);
    endtask
    // stop, load both timers with F0 and th, then start
    task automatic go(input logic [7:0] md, input logic [7:0] ck,
        input logic [7:0] th, input logic [7:0] tc);
        wrr(DMTC_ADDR_TIMER_CONTROL_REG, 8'h00);
        wrr(DMTC_ADDR_CLOCK_CONTROL_REG, ck);
        wrr(DMTC_ADDR_TIMER_MODE_REG, md);
        wrr(DMTC_ADDR_TL0, 8'hF0);
        wrr(DMTC_ADDR_TL1, 8'hF0);
        wrr(DMTC_ADDR_TH0, th);
        wrr(DMTC_ADDR_TH1, th);
        wrr(DMTC_ADDR_TIMER_CONTROL_REG, tc);
    endtask
    // cycles to the flag must fall in a window, then the vector clears it
    task automatic meas(input int f, input int lo, input int hi);
        int n;
        n = 0;
        @(negedge clk_i);
        while ((f ? tf1 : tf0) !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        cmp(8'(n >= lo && n <= hi), 8'h01);
        @(posedge clk_i);
        ack0 <= (f == 0);
        ack1 <= (f == 1);
        @(posedge clk_i);
        ack0 <= 1'b0;
        ack1 <= 1'b0;
        @(negedge clk_i);
        cmp(8'(f ? tf1 : tf0), 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
        wrr(8'h90, 8'h5A);
        rd(8'h90, 8'h00);
        wrr(DMTC_ADDR_TIMER_MODE_REG, 8'hA5);
        rd(DMTC_ADDR_TIMER_MODE_REG, 8'hA5);
        wrr(DMTC_ADDR_TIMER_CONTROL_REG, 8'hA0);
        rd(DMTC_ADDR_TIMER_CONTROL_REG, 8'hA0);
        go(8'h01, 8'h18, 8'hFF, 8'h10);
        meas(0, 56, 72);
        go(8'h01, 8'h00, 8'hFF, 8'h10);
        meas(0, 176, 200);
        go(8'h00, 8'h18, 8'hFF, 8'h10);
        meas(0, 56, 72);
        go(8'h02, 8'h18, 8'hF8, 8'h10);
        meas(0, 56, 72);
        meas(0, 24, 36);
        go(8'h10, 8'h18, 8'hFF, 8'h40);
        meas(1, 56, 72);
        go(8'h10, 8'h08, 8'hFF, 8'h40);
        meas(1, 176, 200);
        u_dmtc_pin_partner.gate(2'h2);
        go(8'h09, 8'h18, 8'hFF, 8'h10);
        repeat (100) @(posedge clk_i);
        cmp(8'(tf0), 8'h00);
        u_dmtc_pin_partner.gate(2'h1);
        meas(0, 56, 80);
        go(8'h90, 8'h18, 8'hFF, 8'h40);
        repeat (100) @(posedge clk_i);
        cmp(8'(tf1), 8'h00);
        u_dmtc_pin_partner.gate(2'h3);
        meas(1, 56, 80);
        go(8'h03, 8'h18, 8'hF0, 8'h40);
        meas(1, 56, 72);
        cmp(8'(tf0), 8'h00);
        go(8'h55, 8'h18, 8'h00, 8'h50);
        u_dmtc_pin_partner.pulse(11'h001 << DMTC_P0_T0_BIT, 3);
        u_dmtc_pin_partner.pulse(11'h001 << DMTC_P0_T1_BIT, 5);
        u_dmtc_pin_partner.pulse(11'h100 << DMTC_P1_T2_BIT, 2);
        rd(DMTC_ADDR_TL0, 8'hF3);
        rd(DMTC_ADDR_TL1, 8'hF5);
        cmp(8'(ev2_n), 8'h02);
        end_of_test();
    end
endmodule // test_dual_mode_timer_counter
`default_nettype wire
